// *** hw/ses_status_protect.sv ***
// Purpose: status register and write protection of a serial eeprom
// Assumes: serial pins oversampled by i_mclk, serial clock mode 0
// Notes: i_rst stands for power-up; array datapath lives outside
//
// Function
// - latch must be set before any write
// - after set-latch opcode, wait for deselect
// - clear-latch opcode clears latch, then waits
// - latch cleared at power-up, clear, write ends
// - status read accepted at any time
// - status byte repeats while still selected
// - busy bit high only during write cycle
// - latch low rejects all write commands
// - status byte layout lock,000,guard,latch,busy
// - guard bits kept, block matching array writes
// - lock and guard pin low refuse status writes
// - status write is opcode plus one byte
// - valid deselect starts timed write cycle
// - latch cleared when status write cycle ends
// - new kept bits apply after cycle ends
// - bits 6..4,1,0 not written; 6..4 zero
// - otherwise status writable with latch set
// - shipped lock bit is zero
// - hardware mode in either entry order, exits pin
// - msb-first opcodes 06, 04, 05, 01
// - guard field 00 none, 01 qtr, 10 half, 11 all
// - writes need clock count multiple of eight
`timescale 1ns/10ps
`include "ses_defs.svh"

module ses_status_protect #(
  parameter int WR_CYCLES = `SES_WR_CYCLES
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic i_sdi,
  input wire logic i_guard_n,
  output logic o_sdo,
  output logic o_sdo_oe,
  output logic [7:0] o_status,
  output logic o_arr_wr_go,
  output logic [12:0] o_arr_wr_addr
);

  localparam int CW = $clog2(WR_CYCLES + 1);

  // ============================================================
  // pin synchronisers
  ses_pkg::ses_pins_type pin_a_ff, pin_b_ff, pin_c_ff;
  ses_pkg::ses_pins_type pins_raw;

  assign pins_raw = '{sck: i_sck, cs_n: i_cs_n, sdi: i_sdi,
                      guard_n: i_guard_n};

  // two stages before use; third stage only for edge finding
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      pin_a_ff <= '{sck: 1'b0, cs_n: 1'b1, sdi: 1'b0, guard_n: 1'b1};
      pin_b_ff <= '{sck: 1'b0, cs_n: 1'b1, sdi: 1'b0, guard_n: 1'b1};
      pin_c_ff <= '{sck: 1'b0, cs_n: 1'b1, sdi: 1'b0, guard_n: 1'b1};
    end else begin
      pin_a_ff <= pins_raw;
      pin_b_ff <= pin_a_ff;
      pin_c_ff <= pin_b_ff;
    end
  end

  logic sck_rise, sck_fall, cs_fall, cs_rise;

  // edge events seen by the core clock
  assign sck_rise = pin_b_ff.sck & ~pin_c_ff.sck;
  assign sck_fall = ~pin_b_ff.sck & pin_c_ff.sck;
  assign cs_fall = ~pin_b_ff.cs_n & pin_c_ff.cs_n;
  assign cs_rise = pin_b_ff.cs_n & ~pin_c_ff.cs_n;

  // ============================================================
  // state
  ses_pkg::ses_state_type state_ff, nxt_state;
  ses_pkg::ses_nv_type nv_ff, nxt_nv, pend_ff, nxt_pend;
  logic [15:0] sh_ff, nxt_sh;
  logic [2:0] bit_cnt_ff, nxt_bit_cnt;
  logic [1:0] byte_cnt_ff, nxt_byte_cnt;
  logic [12:0] addr_ff, nxt_addr;
  logic [7:0] cap_ff, nxt_cap;
  logic [CW-1:0] tmr_ff, nxt_tmr;
  logic latch_ff, nxt_latch;
  logic busy_ff, nxt_busy;
  logic is_stat_wr_ff, nxt_is_stat_wr;
  logic pend_nv_ff, nxt_pend_nv;
  logic armed_ff, nxt_armed;
  logic sdo_ff, nxt_sdo;
  logic oe_ff, nxt_oe;
  logic go_ff, nxt_go;

  // ============================================================
  // decoded status and protection
  logic [7:0] status;
  logic hw_guard_mode;
  logic addr_guarded;
  logic [7:0] opc;
  logic [12:0] wr_addr;

  // mode from lock bit and pin
  // level-based, so entry order does not matter and only pin exits
  assign hw_guard_mode = nv_ff.lock & ~pin_b_ff.guard_n;

  always_comb begin
    status = 8'h00;
    status[`SES_BIT_LOCK] = nv_ff.lock;
    status[`SES_BIT_GUARD_HI] = nv_ff.guard[1];
    status[`SES_BIT_GUARD_LO] = nv_ff.guard[0];
    status[`SES_BIT_LATCH] = latch_ff;
    status[`SES_BIT_BUSY] = busy_ff;
  end

  assign opc = {sh_ff[6:0], pin_b_ff.sdi};
  assign wr_addr = addr_ff;

  always_comb begin
    case (nv_ff.guard)
      2'h1: addr_guarded = (wr_addr >= `SES_GUARD_QTR_BASE);
      2'h2: addr_guarded = (wr_addr >= `SES_GUARD_HALF_BASE);
      2'h3: addr_guarded = 1'b1;
      default: addr_guarded = 1'b0;
    endcase
  end

  // ============================================================
  // command engine next state
  always_comb begin
    nxt_state = state_ff;
    nxt_nv = nv_ff;
    nxt_pend = pend_ff;
    nxt_sh = sh_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_byte_cnt = byte_cnt_ff;
    nxt_addr = addr_ff;
    nxt_cap = cap_ff;
    nxt_tmr = tmr_ff;
    nxt_latch = latch_ff;
    nxt_busy = busy_ff;
    nxt_is_stat_wr = is_stat_wr_ff;
    nxt_pend_nv = pend_nv_ff;
    nxt_armed = armed_ff | pin_b_ff.cs_n;
    nxt_sdo = sdo_ff;
    nxt_oe = oe_ff;
    nxt_go = 1'b0;

    if (busy_ff) begin
      if (tmr_ff == '0) begin
        nxt_busy = 1'b0;
        nxt_latch = 1'b0;
        if (pend_nv_ff) begin
          nxt_nv = pend_ff;
        end
        nxt_pend_nv = 1'b0;
      end else begin
        nxt_tmr = tmr_ff - 1'b1;
      end
    end

    if (cs_rise) begin
      nxt_state = ses_pkg::ST_IDLE;
      nxt_oe = 1'b0;
      // deselect must fall on a byte boundary
      if (state_ff == ses_pkg::ST_DATA && bit_cnt_ff == 3'h0 &&
          byte_cnt_ff != 2'h0) begin
        if (is_stat_wr_ff) begin
          if (byte_cnt_ff == 2'h1 && latch_ff && !busy_ff &&
              !hw_guard_mode) begin
            nxt_pend = '{lock: cap_ff[`SES_BIT_LOCK],
                         guard: cap_ff[`SES_BIT_GUARD_HI:
                                       `SES_BIT_GUARD_LO]};
            nxt_pend_nv = 1'b1;
            nxt_busy = 1'b1;
            nxt_tmr = CW'(WR_CYCLES - 1);
          end
        end else begin
          if (latch_ff && !busy_ff && !addr_guarded) begin
            nxt_busy = 1'b1;
            nxt_tmr = CW'(WR_CYCLES - 1);
            nxt_go = 1'b1;
          end
        end
      end
    end else if (cs_fall && armed_ff) begin
      nxt_state = ses_pkg::ST_OPC;
      nxt_bit_cnt = 3'h0;
      nxt_byte_cnt = 2'h0;
    end else if (sck_rise && !pin_b_ff.cs_n) begin
      nxt_sh = {sh_ff[14:0], pin_b_ff.sdi};
      nxt_bit_cnt = bit_cnt_ff + 3'h1;
      case (state_ff)
        ses_pkg::ST_OPC: begin
          if (bit_cnt_ff == 3'h7) begin
            case (opc)
              `SES_OP_SET_LATCH: begin
                // only path that sets the latch
                nxt_latch = 1'b1;
                nxt_state = ses_pkg::ST_WAIT;
              end
              `SES_OP_CLR_LATCH: begin
                nxt_latch = 1'b0;
                nxt_state = ses_pkg::ST_WAIT;
              end
              `SES_OP_READ_STATE: begin
                nxt_state = ses_pkg::ST_READ;
              end
              `SES_OP_WRITE_STATE: begin
                nxt_is_stat_wr = 1'b1;
                nxt_state = ses_pkg::ST_DATA;
              end
              `SES_OP_ARRAY_WRITE: begin
                nxt_is_stat_wr = 1'b0;
                nxt_state = ses_pkg::ST_ADDR;
              end
              default: begin
                nxt_state = ses_pkg::ST_WAIT;
              end
            endcase
          end
        end
        ses_pkg::ST_ADDR: begin
          if (bit_cnt_ff == 3'h7) begin
            if (byte_cnt_ff == 2'h1) begin
              nxt_addr = {sh_ff[11:0], pin_b_ff.sdi};
              nxt_byte_cnt = 2'h0;
              nxt_state = ses_pkg::ST_DATA;
            end else begin
              nxt_byte_cnt = byte_cnt_ff + 2'h1;
            end
          end
        end
        ses_pkg::ST_DATA: begin
          if (bit_cnt_ff == 3'h7) begin
            // saturate: any count above one marks a long frame
            if (byte_cnt_ff != 2'h3) begin
              nxt_byte_cnt = byte_cnt_ff + 2'h1;
            end
            nxt_cap = opc;
          end
        end
        default: begin
          nxt_sh = {sh_ff[14:0], pin_b_ff.sdi};
        end
      endcase
    end else if (sck_fall && !pin_b_ff.cs_n &&
                 state_ff == ses_pkg::ST_READ) begin
      // re-sample status every byte, drive on fall
      nxt_oe = 1'b1;
      if (bit_cnt_ff == 3'h0) begin
        nxt_cap = status;
        nxt_sdo = status[7];
      end else begin
        nxt_sdo = cap_ff[3'h7 - bit_cnt_ff];
      end
    end
  end

  // ============================================================
  // command engine registers
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      state_ff <= ses_pkg::ST_IDLE;
      nv_ff <= '{lock: `SES_RST_LOCK, guard: `SES_RST_GUARD};
      pend_ff <= '{lock: `SES_RST_LOCK, guard: `SES_RST_GUARD};
      sh_ff <= 16'h0000;
      bit_cnt_ff <= 3'h0;
      byte_cnt_ff <= 2'h0;
      addr_ff <= 13'h0000;
      cap_ff <= 8'h00;
      tmr_ff <= '0;
      latch_ff <= 1'b0;
      busy_ff <= 1'b0;
      is_stat_wr_ff <= 1'b0;
      pend_nv_ff <= 1'b0;
      armed_ff <= 1'b0;
      sdo_ff <= 1'b0;
      oe_ff <= 1'b0;
      go_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      nv_ff <= nxt_nv;
      pend_ff <= nxt_pend;
      sh_ff <= nxt_sh;
      bit_cnt_ff <= nxt_bit_cnt;
      byte_cnt_ff <= nxt_byte_cnt;
      addr_ff <= nxt_addr;
      cap_ff <= nxt_cap;
      tmr_ff <= nxt_tmr;
      latch_ff <= nxt_latch;
      busy_ff <= nxt_busy;
      is_stat_wr_ff <= nxt_is_stat_wr;
      pend_nv_ff <= nxt_pend_nv;
      armed_ff <= nxt_armed;
      sdo_ff <= nxt_sdo;
      oe_ff <= nxt_oe;
      go_ff <= nxt_go;
    end
  end

  // ============================================================
  // outputs
  // enable from the first status bit driven until deselect
  assign o_sdo = sdo_ff;
  assign o_sdo_oe = oe_ff;
  assign o_status = status;
  assign o_arr_wr_go = go_ff;
  assign o_arr_wr_addr = addr_ff;

endmodule : ses_status_protect

// *** include/ses_defs.svh ***
// Purpose: constants of the status and protection block
// Assumes: included by bare name, definitions only
// Notes: opcodes are sent msb first
`ifndef SES_DEFS_SVH
`define SES_DEFS_SVH

// ============================================================
// command opcodes
`define SES_OP_SET_LATCH 8'h06
`define SES_OP_CLR_LATCH 8'h04
`define SES_OP_READ_STATE 8'h05
`define SES_OP_WRITE_STATE 8'h01
`define SES_OP_ARRAY_WRITE 8'h02

// ============================================================
// status byte bit positions
`define SES_BIT_LOCK 7
`define SES_BIT_GUARD_HI 3
`define SES_BIT_GUARD_LO 2
`define SES_BIT_LATCH 1
`define SES_BIT_BUSY 0

// ============================================================
// reset (shipped) values of the kept bits
`define SES_RST_LOCK 1'b0
`define SES_RST_GUARD 2'h0

// ============================================================
// guarded region lower bounds, 13-bit array address
`define SES_GUARD_QTR_BASE 13'h1800
`define SES_GUARD_HALF_BASE 13'h1000

// ============================================================
// timing: self-timed cycle and core clock, in ns
`define SES_WR_TIME_NS 5000000
`define SES_CLK_NS 40
`define SES_WR_CYCLES ((`SES_WR_TIME_NS + `SES_CLK_NS - 1) / `SES_CLK_NS)

`endif

// *** include/ses_pkg.sv ***
// Purpose: types of the status and protection block
// Assumes: nothing
// Notes: constants live in ses_defs.svh
package ses_pkg;

  // ============================================================
  // non-volatile status fields
  typedef struct packed {
    logic lock;
    logic [1:0] guard;
  } ses_nv_type;

  // ============================================================
  // synchronised serial pins
  typedef struct packed {
    logic sck;
    logic cs_n;
    logic sdi;
    logic guard_n;
  } ses_pins_type;

  // ============================================================
  // command engine states, one-hot
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_OPC  = 6'h02,
    ST_ADDR = 6'h04,
    ST_DATA = 6'h08,
    ST_READ = 6'h10,
    ST_WAIT = 6'h20
  } ses_state_type;

endpackage : ses_pkg

// *** sim/ses_spi_master.sv ***
// Purpose: behavioural serial bus master facing the block
// Assumes: mode 0, serial clock of 8 core cycles
// Notes: one o_rx_vld pulse per byte read after the opcode
`timescale 1ns/10ps
module ses_spi_master (
  input wire logic i_mclk,
  input wire logic i_sdo,
  output logic o_sck,
  output logic o_cs_n,
  output logic o_sdi,
  output logic [7:0] o_rx,
  output logic o_rx_vld
);
  // idle levels; clock stands still between frames
  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_sdi = 1'b0;
    o_rx_vld = 1'b0;
  end
  task automatic half;
    repeat (4) @(negedge i_mclk);
  endtask : half
  // one frame of n bits, then a variable idle gap
  task automatic frame(input logic [31:0] d, input int n, input bit rd,
    input int gap);
    o_cs_n = 1'b0;
    half();
    for (int i = 0; i < n; i++) begin
      o_sdi = d[n-1-i];
      half();
      o_rx = {o_rx[6:0], i_sdo};
      o_sck = 1'b1;
      half();
      o_sck = 1'b0;
      if (rd && i > 7 && i % 8 == 7) begin
        o_rx_vld = 1'b1;
        @(negedge i_mclk);
        o_rx_vld = 1'b0;
      end
    end
    o_cs_n = 1'b1;
    o_sdi = ~o_sdi;
    repeat (gap) @(negedge i_mclk);
  endtask : frame
endmodule : ses_spi_master

// *** sim/ses_status_protect_properties.sv ***
// Purpose: port checker of the status and protection block
// Assumes: WR_CYCLES equals the bound instance's value
// Notes: bound to the design after the module
`timescale 1ns/10ps
module ses_status_protect_chk #(
  parameter int WR_CYCLES = 20
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic i_sdi,
  input wire logic i_guard_n,
  input wire logic o_sdo,
  input wire logic o_sdo_oe,
  input wire logic [7:0] o_status,
  input wire logic o_arr_wr_go,
  input wire logic [12:0] o_arr_wr_addr
);
  // ============================================================
  // helpers
  int busy_cnt_ff;
  int nxt_busy_cnt;
  logic guard_hit;
  // busy length counter, too long for a repetition
  always_comb begin
    nxt_busy_cnt = o_status[0] ? busy_cnt_ff + 1 : 0;
  end
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      busy_cnt_ff <= 0;
    end else begin
      busy_cnt_ff <= nxt_busy_cnt;
    end
  end
  // address falls inside the guarded region
  assign guard_hit = (o_status[3:2] == 2'h3) ||
    (o_status[3:2] == 2'h2 && o_arr_wr_addr >= 13'h1000) ||
    (o_status[3:2] == 2'h1 && o_arr_wr_addr >= 13'h1800);

  // ============================================================
  // assertions
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  sequence s_quiet;
    i_cs_n [*6];
  endsequence
  a_zero_field: assert property (
    o_status[6:4] == 3'h0) else $error("status bits 6..4 not zero");
  a_oe_deselect: assert property (
    s_quiet |-> !o_sdo_oe) else $error("output driven while deselected");
  a_busy_length: assert property (
    $fell(o_status[0]) |-> busy_cnt_ff == WR_CYCLES)
    else $error("write cycle length wrong");
  a_latch_end: assert property (
    $fell(o_status[0]) |-> !o_status[1]) else $error("latch kept at end");
  a_nv_commit: assert property (
    $changed({o_status[7], o_status[3:2]}) |-> $fell(o_status[0]))
    else $error("kept bits changed outside cycle end");
  a_go_allowed: assert property (
    o_arr_wr_go |-> $past(o_status[1]) && !guard_hit)
    else $error("array write started without latch or in guard");
  a_start_deselect: assert property (
    $rose(o_status[0]) |-> i_cs_n && $past(o_status[1]))
    else $error("cycle started while selected or unlatched");
  a_hw_frozen: assert property (
    $changed({o_status[7], o_status[3:2]}) |->
    !($past(o_status[7]) && !i_guard_n))
    else $error("kept bits changed in hardware mode");
endmodule : ses_status_protect_chk

bind ses_status_protect ses_status_protect_chk #(.WR_CYCLES(WR_CYCLES))
  u_chk (.i_mclk, .i_rst, .i_sck, .i_cs_n, .i_sdi, .i_guard_n, .o_sdo,
  .o_sdo_oe, .o_status, .o_arr_wr_go, .o_arr_wr_addr);

// *** sim/spi_eeprom_status_protect_tb_top.sv ***
// Purpose: self-checking bench of the status and protection block
// Assumes: write cycle shortened to 400 core cycles
// Notes: read bytes are queued and compared by a watcher
`timescale 1ns/10ps
module spi_eeprom_status_protect_tb_top;
  localparam int WR_LEN = 400;
  logic i_mclk, i_rst, i_sck, i_cs_n, i_sdi, i_guard_n, sdo_line;
  logic o_sdo, o_sdo_oe, o_arr_wr_go, rx_vld;
  logic [7:0] o_status, rx;
  logic [12:0] o_arr_wr_addr;
  logic [12:0] exp_q[$];
  logic [12:0] adr_q[$];
  logic [12:0] bnd[4] = '{13'h0FFF, 13'h1000, 13'h17FF, 13'h1800};
  int fails;
  int cmp_count;
  // released data line reads high, as through a pull-up
  assign sdo_line = o_sdo_oe ? o_sdo : 1'b1;
  ses_status_protect #(.WR_CYCLES(WR_LEN)) i_dut (.i_mclk, .i_rst, .i_sck,
    .i_cs_n, .i_sdi, .i_guard_n, .o_sdo, .o_sdo_oe, .o_status,
    .o_arr_wr_go, .o_arr_wr_addr);
  ses_spi_master i_mst (.i_mclk, .i_sdo(sdo_line), .o_sck(i_sck),
    .o_cs_n(i_cs_n), .o_sdi(i_sdi), .o_rx(rx), .o_rx_vld(rx_vld));
  initial begin
    i_mclk = 1'b0;
    forever #20 i_mclk = ~i_mclk;
  end

  // ============================================================
  // checking and closing
  task automatic check(input logic [12:0] seen, input logic [12:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test
  // watcher takes the oldest note whenever a result shows
  // read bytes: valid rises on the falling edge, so take it on the rise
  always @(posedge i_mclk) begin
    if (rx_vld === 1'b1) check({5'h0, rx}, exp_q.pop_front());
  end
  // start pulse: look mid-cycle, away from the edge that launches it
  always @(negedge i_mclk) begin
    if (o_arr_wr_go === 1'b1) check(o_arr_wr_addr, adr_q.pop_front());
  end

  // ============================================================
  // bus tasks
  function automatic int gap();
    return 6 + $urandom % 12;
  endfunction : gap
  task automatic cmd(input logic [7:0] op);
    i_mst.frame({24'h0, op}, 8, 0, gap());
  endtask : cmd
  task automatic wst(input logic [7:0] d);
    i_mst.frame({16'h0, 8'h01, d}, 16, 0, gap());
  endtask : wst
  task automatic rd(input logic [7:0] e, input int n);
    repeat (n) exp_q.push_back({5'h0, e});
    i_mst.frame(32'h05 << (8 * n), 8 + 8 * n, 1, gap());
  endtask : rd
  // wait busy clear
  // bounded, so a stuck cycle ends the run instead of hanging
  task automatic idle;
    int n;
    n = 0;
    while (o_status[0] !== 1'b0 && n < 2 * WR_LEN) begin
      @(negedge i_mclk);
      n++;
    end
    if (n >= 2 * WR_LEN) begin
      fails++;
      finish_test();
    end
  endtask : idle

  // ============================================================
  // main sequence
  initial begin
    int g;
    logic [12:0] a;
    bit lat;
    bit hit;
    i_rst = 1'b1;
    i_guard_n = 1'b0;
    fails = 0;
    cmp_count = 0;
    g = $urandom(18350);
    repeat (4) @(negedge i_mclk);
    i_rst = 1'b0;
    repeat (4) @(negedge i_mclk);
    rd(8'h00, 1);
    wst(8'h8C);
    rd(8'h00, 1);
    // trailing bits after set-latch are ignored
    i_mst.frame(32'h0604, 16, 0, 8);
    rd(8'h02, 1);
    cmd(8'h04);
    rd(8'h00, 1);
    // off-boundary status writes keep the latch
    cmd(8'h06);
    i_mst.frame(32'h00C6, 15, 0, 8);
    i_mst.frame(32'h0318, 17, 0, 8);
    rd(8'h02, 1);
    // pin low, lock clear: accepted; old bits seen while busy
    wst(8'h8F);
    rd(8'h03, 2);
    idle();
    check({5'h0, o_status}, 13'h008C);
    cmd(8'h06);
    wst(8'h00);
    idle();
    check({5'h0, o_status}, 13'h008E);
    // pin high leaves hardware mode; latch still set
    i_guard_n = 1'b1;
    repeat (8) @(negedge i_mclk);
    wst(8'h00);
    idle();
    check({5'h0, o_status}, 13'h0000);
    // array writes at region edges under every guard value
    for (int k = 0; k < 20; k++) begin
      g = k / 5;
      if (k % 5 == 0) begin
        cmd(8'h06);
        wst({4'h0, g[1:0], 2'h0});
        idle();
      end
      lat = (k % 5 != 4);
      a = lat ? bnd[k % 5] : 13'($urandom);
      hit = (g == 3) || (g == 2 && a >= 13'h1000) ||
        (g == 1 && a >= 13'h1800);
      if (lat) cmd(8'h06);
      // latch cleared, a refused write may leave it set
      if (!lat) cmd(8'h04);
      if (lat && !hit) adr_q.push_back(a);
      i_mst.frame({8'h02, 3'h0, a, 8'hA5}, 32, 0, gap());
      idle();
      check({5'h0, o_status}, {9'h0, g[1:0], lat && hit, 1'b0});
    end
    check(13'(adr_q.size()), 13'h0000);
    check(13'(exp_q.size()), 13'h0000);
    finish_test();
  end
endmodule : spi_eeprom_status_protect_tb_top
